//--- hw/rim_lock_ctrl.v
/*
 * reference input monitor and lock control: measures the reference period
 * in timing clock cycles, reports a range code, times loss of input and
 * drives lock, output enable and loop bandwidth.
 * assumes clk is the internal timing clock and ref_in is asynchronous.
 */
`timescale 1ns/1ns
`include "rim_defs.vh"

module rim_lock_ctrl #(
	parameter TIMEOUT_CYCLES = 32'd1 << `RIM_TIMEOUT_LOG2,
	parameter SKIP_CYCLES    = `RIM_SKIP_CYCLES,
	parameter REACQ_CYCLES   = `RIM_REACQ_CYCLES,
	parameter RATIO_W        = 32
) (
	// clock and reset
	input  wire               clk,
	input  wire               reset_n,
	// reference input from the external source
	input  wire               ref_in,
	// software controls
	input  wire               pulse_skip_enable,
	input  wire               output_on_unlock_enable,
	input  wire               auto_modifier_enable,
	input  wire [2:0]         min_loop_bandwidth_select,
	input  wire [RATIO_W-1:0] manual_ratio,
	// status and controls toward the loop
	output reg  [1:0]         input_ratio_range_code,
	output reg                lock_status,
	output reg                synth_output_enable,
	output reg  [2:0]         loop_bandwidth,
	output reg  [RATIO_W-1:0] effective_ratio,
	output reg  [31:0]        ref_period
);

	localparam ST_ACQUIRE = 2'h0;
	localparam ST_LOCKED  = 2'h1;
	localparam ST_HOLD    = 2'h2;
	localparam ST_LOST    = 2'h3;

	reg        ref_s1;
	reg        ref_s2;
	reg        ref_s3;
	reg [31:0] gap_count;
	reg [31:0] acq_count;
	reg [1:0]  state;
	reg        skip_ride;
	reg        timed_out;
	// last measured period spans a missing-pulse gap, not a true period
	reg        gap_span;

	wire       ref_edge = ref_s2 & ~ref_s3;
	wire [31:0] tol     = ref_period >> `RIM_GLITCH_SHIFT;
	wire       period_bad = (ref_period != 32'h0) &&
		((gap_count + 32'd1 + tol < ref_period) ||
		 (gap_count + 32'd1 > ref_period + tol && gap_count < SKIP_CYCLES));

	// ===================================================================
	// input synchroniser and period measurement
	// ===================================================================
	// restart on edge
	always @(posedge clk) begin
		if (!reset_n) begin
			ref_s1     <= 1'b0;
			ref_s2     <= 1'b0;
			ref_s3     <= 1'b0;
			gap_count  <= 32'h0;
			ref_period <= 32'h0;
		end else begin
			ref_s1 <= ref_in;
			ref_s2 <= ref_s1;
			ref_s3 <= ref_s2;
			if (ref_edge) begin
				gap_count  <= 32'h0;
				ref_period <= gap_count + 32'd1;
			end else if (gap_count != 32'hffffffff) begin
				gap_count <= gap_count + 32'd1;
			end
		end
	end

	// ===================================================================
	// range code and effective ratio
	// ===================================================================
	// ratio range compare
	always @(posedge clk) begin
		if (!reset_n) begin
			input_ratio_range_code <= `RIM_RANGE_ABOVE;
			effective_ratio        <= {RATIO_W{1'b0}};
		end else begin
			if (ref_period > `RIM_RATIO_HIGH)
				input_ratio_range_code <= `RIM_RANGE_ABOVE;
			else if (ref_period >= `RIM_RATIO_LOW)
				input_ratio_range_code <= `RIM_RANGE_MID;
			else
				input_ratio_range_code <= `RIM_RANGE_BELOW;
			if (!auto_modifier_enable)
				effective_ratio <= manual_ratio;
			else if (input_ratio_range_code == `RIM_RANGE_MID)
				effective_ratio <= manual_ratio >> `RIM_SHIFT_HALF;
			else if (input_ratio_range_code == `RIM_RANGE_BELOW)
				effective_ratio <= manual_ratio >> `RIM_SHIFT_QUARTER;
			else
				effective_ratio <= manual_ratio >> `RIM_SHIFT_X1;
		end
	end

	// ===================================================================
	// lock state machine
	// ===================================================================
	always @(posedge clk) begin
		if (!reset_n) begin
			state     <= ST_ACQUIRE;
			acq_count <= 32'h0;
			skip_ride <= 1'b0;
			timed_out <= 1'b0;
			gap_span  <= 1'b0;
		end else begin
			// a gap-long measurement must not read as a glitch on the next edge
			if (ref_edge)
				gap_span <= 1'b0;
			case (state)
			ST_ACQUIRE: begin
				if (ref_edge && !skip_ride && !timed_out && !gap_span && period_bad)
					acq_count <= 32'h0;
				else if (gap_count >= TIMEOUT_CYCLES) begin
					state     <= ST_LOST;
					timed_out <= 1'b1;
					skip_ride <= 1'b0;
				end else if (acq_count >= REACQ_CYCLES - 1) begin
					state     <= ST_LOCKED;
					acq_count <= 32'h0;
					skip_ride <= 1'b0;
					timed_out <= 1'b0;
				end else if (ref_period != 32'h0) begin
					acq_count <= acq_count + 32'd1;
				end
			end
			ST_LOCKED: begin
				if (ref_edge && period_bad && !gap_span) begin
					state <= ST_ACQUIRE;
				end else if (!ref_edge && gap_count + 32'd1 > ref_period + tol) begin
					state <= ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (gap_count >= TIMEOUT_CYCLES - 1) begin
					state     <= ST_LOST;
					timed_out <= 1'b1;
				end else if (ref_edge) begin
					state     <= ST_ACQUIRE;
					gap_span  <= 1'b1;
					skip_ride <= pulse_skip_enable && (gap_count < SKIP_CYCLES);
				end
			end
			default: begin
				if (ref_edge) begin
					state     <= ST_ACQUIRE;
					acq_count <= 32'h0;
					gap_span  <= 1'b1;
				end
			end
			endcase
		end
	end

	// ===================================================================
	// outputs toward the synthesizer
	// ===================================================================
	// lock status
	always @(posedge clk) begin
		if (!reset_n) begin
			lock_status         <= 1'b0;
			synth_output_enable <= 1'b0;
			loop_bandwidth      <= `RIM_BW_WIDE;
		end else begin
			lock_status <= (state == ST_LOCKED) || (state == ST_HOLD) ||
				(state == ST_ACQUIRE && skip_ride);
			if (state == ST_LOCKED || state == ST_HOLD || skip_ride)
				synth_output_enable <= 1'b1;
			else
				synth_output_enable <= output_on_unlock_enable;
			if (state == ST_LOCKED || state == ST_HOLD)
				loop_bandwidth <= min_loop_bandwidth_select;
			else
				loop_bandwidth <= `RIM_BW_WIDE;
		end
	end

endmodule // rim_lock_ctrl

//--- hw/rim_defs.vh
/*
 * constants for the reference input monitor and lock control block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef RIM_DEFS_VH
`define RIM_DEFS_VH

// ratio thresholds between timing clock and reference input
`define RIM_RATIO_HIGH      32'd224
`define RIM_RATIO_LOW       32'd96

// range codes
`define RIM_RANGE_ABOVE     2'h0
`define RIM_RANGE_MID       2'h1
`define RIM_RANGE_BELOW     2'h2
`define RIM_RANGE_RSVD      2'h3

// auto modifier as a right shift: 1, 0.5, 0.25
`define RIM_SHIFT_X1        2'h0
`define RIM_SHIFT_HALF      2'h1
`define RIM_SHIFT_QUARTER   2'h2

// loss-of-input timeout, log2 of timing clock cycles
`define RIM_TIMEOUT_LOG2    23
// skip window in ms and timing clock rate in Hz
`define RIM_SKIP_MS         20
`define RIM_CLK_HZ          20000000
`define RIM_SKIP_CYCLES     ((`RIM_CLK_HZ / 1000) * `RIM_SKIP_MS)
// reacquisition time in microseconds
`define RIM_REACQ_US        1000
`define RIM_REACQ_CYCLES    ((`RIM_CLK_HZ / 1000000) * `RIM_REACQ_US)

// wide loop bandwidth code used during acquisition
`define RIM_BW_WIDE         3'h7
// period tolerance for a glitch, as a right shift of the old period
`define RIM_GLITCH_SHIFT    2

`endif

//--- test/rim_ref_source.sv
/* reference clock source model.
   assumes period in clk cycles, at least 2. */
`timescale 1ns/1ns
// ====
// source
module rim_ref_source (
	// clock and controls
	input  logic        clk,
	input  logic        run,
	input  logic [31:0] period,
	// reference output
	output logic        ref_out
);
	logic [31:0] cnt = 32'h0;
	initial ref_out = 1'b0;
	// line stands low while stopped
	always @(posedge clk) begin
		if (!run || cnt >= period - 1)
			cnt <= 32'h0;
		else
			cnt <= cnt + 1;
		ref_out <= run && (cnt < period / 2);
	end
endmodule // rim_ref_source

//--- test/rim_lock_ctrl_assertions.sv
/* checker on the lock control ports.
   assumes bind onto rim_lock_ctrl. */
`timescale 1ns/1ns
// ====
// checker
module rim_lock_ctrl_assertions #(
	parameter TIMEOUT_CYCLES = 32'd1 << 23,
	parameter REACQ_CYCLES   = 20000,
	parameter RATIO_W        = 32
) (
	// clock and reset
	input logic               clk,
	input logic               reset_n,
	// inputs
	input logic               ref_in,
	input logic               output_on_unlock_enable,
	input logic               auto_modifier_enable,
	input logic [2:0]         min_loop_bandwidth_select,
	input logic [RATIO_W-1:0] manual_ratio,
	// outputs
	input logic [1:0]         input_ratio_range_code,
	input logic               lock_status,
	input logic               synth_output_enable,
	input logic [2:0]         loop_bandwidth,
	input logic [RATIO_W-1:0] effective_ratio,
	input logic [31:0]        ref_period
);
	logic [31:0] gap;
	logic [31:0] unl;
	logic        ref_q;
	// cycles since a raw edge, and cycles unlocked
	always @(posedge clk) begin
		ref_q <= ref_in;
		if (!reset_n || (ref_in && !ref_q))
			gap <= 32'h0;
		else if (gap < TIMEOUT_CYCLES + 16)
			gap <= gap + 1;
		if (!reset_n || lock_status)
			unl <= 32'h0;
		else
			unl <= unl + 1;
	end
	function automatic logic [1:0] rng(input logic [31:0] p);
		rng = (p > 224) ? 2'h0 : (p >= 96) ? 2'h1 : 2'h2;
	endfunction
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_acquired;
		!lock_status ##1 lock_status;
	endsequence
	sequence s_dropped;
		lock_status ##1 !lock_status;
	endsequence
	chk_range_legal: assert property (input_ratio_range_code != 2'h3)
		else $error("reserved range code");
	chk_range_period: assert property ($changed(ref_period) |=>
		input_ratio_range_code == rng($past(ref_period))) else $error("range code wrong");
	chk_ratio_shift: assert property (auto_modifier_enable && $past(auto_modifier_enable)
		&& $past(reset_n) && $stable(input_ratio_range_code) && $stable(manual_ratio)
		|-> effective_ratio == (manual_ratio >> input_ratio_range_code)) else $error("ratio");
	chk_bw_wide: assert property (!lock_status |-> loop_bandwidth == 3'h7)
		else $error("bandwidth not wide");
	chk_bw_select: assert property (s_acquired |->
		loop_bandwidth == min_loop_bandwidth_select) else $error("bandwidth select");
	chk_oe_drop: assert property (s_dropped |->
		synth_output_enable == $past(output_on_unlock_enable)) else $error("unlock output");
	chk_oe_resume: assert property (s_acquired |-> synth_output_enable)
		else $error("output not resumed");
	chk_reacq_time: assert property ($rose(lock_status) |-> unl >= REACQ_CYCLES)
		else $error("locked too early");
	chk_timeout_unlock: assert property (gap >= TIMEOUT_CYCLES + 8 |-> !lock_status)
		else $error("no unlock on timeout");
endmodule // rim_lock_ctrl_assertions
bind rim_lock_ctrl rim_lock_ctrl_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.REACQ_CYCLES(REACQ_CYCLES), .RATIO_W(RATIO_W)) chk (.clk, .reset_n, .ref_in,
	.output_on_unlock_enable, .auto_modifier_enable, .min_loop_bandwidth_select,
	.manual_ratio, .input_ratio_range_code, .lock_status, .synth_output_enable,
	.loop_bandwidth, .effective_ratio, .ref_period);

//--- test/test_rim_lock_ctrl.sv
/* bench for rim_lock_ctrl with a reference source model.
   assumes scaled timeout 2000, skip 700, reacquire 20. */
`timescale 1ns/1ns
module test_rim_lock_ctrl;
	logic        clk, reset_n, ref_in, run, skip, oue, lock, oe;
	logic [31:0] period, ref_period, eff;
	logic [1:0]  code;
	logic [2:0]  bw, bsel;
	logic        ame;
	int          err_count, checks_done;
	int          plist[4] = '{225, 224, 96, 95};
	logic [1:0]  clist[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
	rim_lock_ctrl #(.TIMEOUT_CYCLES(2000), .SKIP_CYCLES(700), .REACQ_CYCLES(20)) uut (
		.clk(clk), .reset_n(reset_n), .ref_in(ref_in), .pulse_skip_enable(skip),
		.output_on_unlock_enable(oue), .auto_modifier_enable(ame),
		.min_loop_bandwidth_select(bsel), .manual_ratio(32'h100),
		.input_ratio_range_code(code), .lock_status(lock), .synth_output_enable(oe),
		.loop_bandwidth(bw), .effective_ratio(eff), .ref_period(ref_period));
	rim_ref_source src (.clk(clk), .run(run), .period(period), .ref_out(ref_in));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task cyc(input int n); repeat (n) @(posedge clk); #5; endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_lock(input logic v, input int n);
		for (int i = 0; i < n && lock !== v; i++) cyc(1);
		check(lock, v);
	endtask
	task gap(input int n); @(posedge ref_in); #5; run = 1'b0; cyc(n); endtask
	task final_report;
		if (err_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		final_report;
	end
	initial begin
		{reset_n, run, skip, oue, period, err_count, checks_done} = 0;
		period = 300;
		ame = 1'b1;
		bsel = 3'h2;
		cyc(16);
		check({code, lock, oe, bw}, {2'h0, 1'b0, 1'b0, 3'h7});
		check(eff, 32'h0);
		check(ref_period, 32'h0);
		reset_n = 1'b1;
		run = 1'b1;
		for (int i = 0; i < 4; i++) begin
			period = plist[i];
			cyc(5 * plist[i]);
			check(ref_period, plist[i]);
			check(code, clist[i]);
			check(eff, 32'h100 >> clist[i]);
		end
		ame = 1'b0; cyc(3); check(eff, 32'h100);
		ame = 1'b1;
		period = 300;
		cyc(1500);
		wait_lock(1'b1, 3000);
		check({oe, bw}, 4'ha);
		skip = 1'b1;
		gap(500); check({lock, oe}, 2'h3);
		run = 1'b1; cyc(1500); check({lock, oe}, 2'h3);
		oue = 1'b1;
		gap(1000); check({lock, oe}, 2'h3);
		run = 1'b1; wait_lock(1'b0, 50); check(oe, 1'b1);
		wait_lock(1'b1, 3000);
		{skip, oue} = 2'h0;
		gap(500); check({lock, oe}, 2'h3);
		run = 1'b1; wait_lock(1'b0, 50); check(oe, 1'b0);
		wait_lock(1'b1, 3000);
		gap(1900); check(lock, 1'b1);
		cyc(200); check({lock, oe}, 2'h0);
		bsel = 3'h5;
		run = 1'b1; cyc(10); check(lock, 1'b0);
		wait_lock(1'b1, 3000);
		check({oe, bw}, {1'b1, 3'h5});
		@(posedge ref_in); #5; period = 100;
		wait_lock(1'b0, 150);
		final_report;
	end
endmodule // test_rim_lock_ctrl
